// [rtl/sfb_fifo.sv]
/*
  Synchronous FIFO with valid/ready on both sides, a flush input,
  overwrite of the newest entry, and a fill count.
  Assumes a single clock and a clock enable shared with its parent.
*/
`timescale 1ns/1ps
module sfb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW = $clog2(DEPTH)
) (
  // Clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic overwrite,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [WIDTH-1:0] last_data,
  output logic [AW:0] count
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [WIDTH-1:0] last_pop;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction
  function automatic logic [AW-1:0] dec(input logic [AW-1:0] p);
    dec = (p == '0) ? AW'(DEPTH - 1) : p - 1'b1;
  endfunction

  assign in_ready = (count != (AW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp];
  assign last_data = out_valid ? mem[rp] : last_pop;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wp] <= in_data;
    end else if (ce && in_valid && overwrite && !in_ready) begin
      mem[dec(wp)] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
      last_pop <= '0;
    end else if (ce) begin
      if (flush) begin
        wp <= '0;
        rp <= '0;
        count <= '0;
      end else begin
        if (push) begin
          wp <= inc(wp);
        end
        if (pop) begin
          rp <= inc(rp);
          last_pop <= mem[rp];
        end
        if (push && !pop) begin
          count <= count + 1'b1;
        end else if (pop && !push) begin
          count <= count - 1'b1;
        end
      end
    end
  end
endmodule

// [rtl/sfb_smbus_fifo.sv]
/*
  Transmit and receive byte FIFOs of the SMBus engine, with request
  flags, thresholds, flushes, fill counts and receive length counter.
  Assumes firmware on the 8-bit register port and a serial shift engine
  that reports each received byte and takes transmit bytes.
*/
`timescale 1ns/1ps
// Overview of operation
// RL1: Data port write pushes transmit FIFO; read pops receive FIFO.
// RL2: Writing data while transmit FIFO full replaces newest queued byte.
// RL3: Reading data while receive FIFO empty returns last byte, no underflow.
// RL4: Transmit flush clears transmit FIFO; bit self-clears after one cycle.
// RL5: Receive threshold zero raises receive request when any byte stored.
// RL6: Interrupt when a request flag and its enable are both one.
// RL7: Transmit-not-full reads one with room, zero when full.
// RL8: Master receive with hardware ack keeps acking while length above one.
// RL9: Master receive decrements length per byte, stopping at zero.
// RL10: Byte in master receive with length zero sets flag, stalls bus.
// RL11: Final counted byte acked if ack bit one, nacked if zero.
// RL12: Slave receive with length zero stalls and interrupts every byte.
// RL13: Slave receive nonzero length buffers normally, no decrement.
// RL14: Firmware changes length mid-transfer only while flag set, stalled.
// RL15: Count register bits 6:4 show transmit FIFO fill.
// RL16: Count register bits 2:0 show receive FIFO fill.
// RL17: Interrupt flag holds clock low; clearing it resumes operation.
// RL18: Transmit request at count <= threshold; receive when count > threshold.
// RL19: Receive flush clears receive FIFO; bit self-clears after one cycle.
// RL20: Receive-empty reads one exactly when receive FIFO is empty.
module sfb_smbus_fifo #(
  parameter int DEPTH = 4,
  parameter int BUF_DEPTH = 16,
  parameter int CW = $clog2(DEPTH) + 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Register port
  input wire sfb_pkg::sfb_sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  // Serial engine side
  input wire sfb_pkg::sfb_byte_s rx_byte,
  input wire logic master_mode,
  input wire logic rx_mode,
  input wire logic hw_ack_enable,
  input wire logic ack_bit,
  input wire logic si_set,
  input wire logic si_clear,
  input wire logic tx_take,
  output logic [7:0] tx_data,
  output logic tx_avail,
  output logic si_flag,
  output logic scl_hold,
  output logic ack_out,
  output logic smbus_irq
);
  logic [7:0] fcn0;
  logic [7:0] rx_length_field;
  logic [CW-1:0] tx_byte_count;
  logic [CW-1:0] rx_byte_count;
  logic [7:0] rx_last;
  logic [7:0] tx_head;
  logic tx_has;
  logic rx_has;
  logic tx_not_full;
  logic rx_empty;
  logic tx_request_flag;
  logic rx_request_flag;
  logic data_wr;
  logic data_rd;
  logic rx_push;
  logic rx_room;
  logic rx_stall;
  logic stage_valid;
  logic stage_ready;
  logic [7:0] stage_data;
  logic buf_valid;
  logic [7:0] buf_data;
  logic next_irq;
  logic [7:0] next_rdata;

  function automatic logic sel(input logic [7:0] a);
    sel = (sfr_req.addr == a);
  endfunction

  assign data_wr = sfr_req.wr && sel(sfb_pkg::ADDR_DATA);
  assign data_rd = sfr_req.rd && sel(sfb_pkg::ADDR_DATA);

  // Transmit FIFO; overwrite when full
  sfb_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx (
    .clk(core_clk),
    .rst(sys_rst),
    .ce(clk_en),
    .flush(fcn0[sfb_pkg::TX_FLUSH_BIT]), // see RL4
    .in_valid(data_wr), // see RL1
    .in_ready(tx_not_full),
    .in_data(sfr_req.wdata),
    .overwrite(1'b1), // see RL2
    .out_valid(tx_has),
    .out_ready(tx_take),
    .out_data(tx_head),
    .last_data(),
    .count(tx_byte_count)
  );

  // Receive byte staging; 16-deep buffer absorbs serial bursts
  sfb_fifo #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_rxbuf (
    .clk(core_clk),
    .rst(sys_rst),
    .ce(clk_en),
    .flush(fcn0[sfb_pkg::RX_FLUSH_BIT]),
    .in_valid(rx_byte.valid),
    .in_ready(stage_ready),
    .in_data(rx_byte.data),
    .overwrite(1'b0),
    .out_valid(buf_valid),
    .out_ready(rx_room),
    .out_data(buf_data),
    .last_data(),
    .count()
  );
  assign stage_valid = buf_valid;
  assign stage_data = buf_data;
  assign rx_push = stage_valid && rx_room;

  // Receive FIFO seen by firmware
  sfb_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx (
    .clk(core_clk),
    .rst(sys_rst),
    .ce(clk_en),
    .flush(fcn0[sfb_pkg::RX_FLUSH_BIT]), // see RL19
    .in_valid(stage_valid),
    .in_ready(rx_room),
    .in_data(stage_data),
    .overwrite(1'b0),
    .out_valid(rx_has),
    .out_ready(data_rd), // see RL1
    .out_data(),
    .last_data(rx_last), // see RL3
    .count(rx_byte_count)
  );

  assign rx_empty = !rx_has; // see RL20
  // see RL18
  assign tx_request_flag = tx_byte_count <=
      CW'(fcn0[sfb_pkg::TX_THRESHOLD_LSB +: 2]);
  // Zero threshold gives request on any stored byte; see RL5
  assign rx_request_flag = rx_byte_count >
      CW'(fcn0[sfb_pkg::RX_THRESHOLD_LSB +: 2]);
  // Serial engine waits when no room downstream
  assign rx_stall = !stage_ready;

  // Control zero; flush bits self-clear next cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fcn0 <= sfb_pkg::FCN0_RESET;
    end else if (clk_en) begin
      if (sfr_req.wr && sel(sfb_pkg::ADDR_FCN0)) begin
        fcn0 <= sfr_req.wdata;
      end else begin
        fcn0[sfb_pkg::TX_FLUSH_BIT] <= 1'b0; // see RL4
        fcn0[sfb_pkg::RX_FLUSH_BIT] <= 1'b0; // see RL19
      end
    end
  end

  // Receive length counter
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_length_field <= sfb_pkg::RX_LENGTH_FIELD_RESET;
    end else if (clk_en) begin
      // Firmware write wins; it is expected only while stalled, see RL14
      if (sfr_req.wr && sel(sfb_pkg::ADDR_RX_LENGTH_FIELD)) begin
        rx_length_field <= sfr_req.wdata;
      end else if (rx_byte.valid && master_mode && rx_mode
                   && rx_length_field != 8'h00) begin
        rx_length_field <= rx_length_field - 8'h01; // see RL9, RL13
      end
    end
  end

  // Interrupt flag; hardware set wins over firmware clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      si_flag <= 1'b0;
    end else if (clk_en) begin
      if (si_set
          || (rx_byte.valid && rx_mode && rx_length_field == 8'h00)
          || (rx_byte.valid && rx_mode && master_mode && !hw_ack_enable)) begin
        si_flag <= 1'b1; // see RL10, RL12
      end else if (si_clear) begin
        si_flag <= 1'b0; // see RL17
      end
    end
  end

  // Clock stretch and acknowledge choice
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_hold <= 1'b0;
      ack_out <= 1'b0;
    end else if (clk_en) begin
      // see RL17, RL8
      scl_hold <= si_flag || rx_stall;
      // Keep acking while length remains; last byte follows ack bit
      if (master_mode && rx_mode && hw_ack_enable
          && rx_length_field > 8'h01) begin
        ack_out <= 1'b1; // see RL8
      end else begin
        ack_out <= ack_bit; // see RL11
      end
    end
  end

  always_comb begin
    next_irq = (rx_request_flag && fcn0[sfb_pkg::RX_REQUEST_IRQ_ENABLE_BIT])
        || (tx_request_flag && fcn0[sfb_pkg::TX_REQUEST_IRQ_ENABLE_BIT]); // see RL6
  end

  always_comb begin
    next_rdata = 8'h00;
    case (sfr_req.addr)
      sfb_pkg::ADDR_DATA: next_rdata = rx_last;
      sfb_pkg::ADDR_FCN0: next_rdata = fcn0;
      sfb_pkg::ADDR_FCN1: begin
        next_rdata[sfb_pkg::TX_REQUEST_FLAG_BIT] = tx_request_flag;
        next_rdata[sfb_pkg::TX_NOT_FULL_BIT] = tx_not_full; // see RL7
        next_rdata[sfb_pkg::RX_REQUEST_FLAG_BIT] = rx_request_flag;
        next_rdata[sfb_pkg::RXE_BIT] = rx_empty; // see RL20
      end
      sfb_pkg::ADDR_RX_LENGTH_FIELD: next_rdata = rx_length_field;
      sfb_pkg::ADDR_FCT: begin
        next_rdata[sfb_pkg::TX_BYTE_COUNT_LSB +: 3] = 3'(tx_byte_count); // see RL15
        next_rdata[sfb_pkg::RX_BYTE_COUNT_LSB +: 3] = 3'(rx_byte_count); // see RL16
      end
      default: next_rdata = 8'h00;
    endcase
  end

  // Registered outputs
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
      smbus_irq <= 1'b0;
      tx_data <= 8'h00;
      tx_avail <= 1'b0;
    end else if (clk_en) begin
      sfr_rdata <= next_rdata;
      smbus_irq <= next_irq;
      tx_data <= tx_head;
      tx_avail <= tx_has;
    end
  end

  a_flush_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && fcn0[sfb_pkg::TX_FLUSH_BIT] && !sfr_req.wr |=>
    !fcn0[sfb_pkg::TX_FLUSH_BIT] && tx_byte_count == '0)
    else $error("tx flush did not clear"); // see RL4
  a_tx_not_full_full: assert property (@(posedge core_clk) disable iff (sys_rst)
    tx_not_full == (tx_byte_count != CW'(DEPTH)))
    else $error("tx not full wrong"); // see RL7
  a_rxe_empty: assert property (@(posedge core_clk) disable iff (sys_rst)
    rx_empty == (rx_byte_count == '0))
    else $error("rx empty wrong"); // see RL20
  a_irq_cause: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && rx_request_flag && fcn0[sfb_pkg::RX_REQUEST_IRQ_ENABLE_BIT] |=> smbus_irq)
    else $error("irq missing"); // see RL6
  a_len_dec: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && rx_byte.valid && master_mode && rx_mode && !sfr_req.wr
    && rx_length_field != 8'h00 |=>
    rx_length_field == $past(rx_length_field) - 8'h01)
    else $error("length not decremented"); // see RL9
  a_slave_len: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && !master_mode && !sfr_req.wr |=> $stable(rx_length_field))
    else $error("slave length changed"); // see RL13
  a_zero_stall: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && rx_byte.valid && rx_mode && rx_length_field == 8'h00
    |=> si_flag ##1 scl_hold)
    else $error("no stall at zero length"); // see RL10
  a_rx_req: assert property (@(posedge core_clk) disable iff (sys_rst)
    fcn0[sfb_pkg::RX_THRESHOLD_LSB +: 2] == 2'h0 |-> rx_request_flag == rx_has)
    else $error("rx request wrong"); // see RL5

  default clocking cb_core @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // Full writes replace in place, so the fill never grows
  a_tx_keep: assert property ( // see RL2
    clk_en && data_wr && !tx_not_full && !tx_take
    && !fcn0[sfb_pkg::TX_FLUSH_BIT] |=> tx_byte_count == $past(tx_byte_count))
    else $error("tx overwrite changed fill");
  sequence s_empty_read;
    clk_en && data_rd && rx_empty && !stage_valid
    && !fcn0[sfb_pkg::RX_FLUSH_BIT];
  endsequence
  a_rx_underrun: assert property ( // see RL3
    s_empty_read |=> rx_empty && rx_last == $past(rx_last))
    else $error("empty read disturbed fifo");
  a_irq_tx: assert property ( // see RL6
    clk_en && tx_request_flag && fcn0[sfb_pkg::TX_REQUEST_IRQ_ENABLE_BIT] |=> smbus_irq)
    else $error("tx irq missing");
  a_irq_quiet: assert property ( // see RL6
    clk_en && !(rx_request_flag && fcn0[sfb_pkg::RX_REQUEST_IRQ_ENABLE_BIT])
    && !(tx_request_flag && fcn0[sfb_pkg::TX_REQUEST_IRQ_ENABLE_BIT]) |=> !smbus_irq)
    else $error("irq without cause");
  a_si_hold: assert property ( // see RL17
    clk_en && si_flag |=> scl_hold)
    else $error("clock not held");
  a_si_set: assert property ( // see RL17
    clk_en && si_set |=> si_flag)
    else $error("flag not set");
  a_si_clear: assert property ( // see RL17
    clk_en && si_clear && !si_set && !rx_byte.valid |=> !si_flag)
    else $error("flag not cleared");
  a_ack_keep: assert property ( // see RL8
    clk_en && master_mode && rx_mode && hw_ack_enable
    && rx_length_field > 8'h01 |=> ack_out)
    else $error("ack dropped early");
  a_ack_last: assert property ( // see RL11
    clk_en && !(master_mode && rx_mode && hw_ack_enable
    && rx_length_field > 8'h01) |=> ack_out == $past(ack_bit))
    else $error("last ack wrong");
  a_rx_flush: assert property ( // see RL19
    clk_en && fcn0[sfb_pkg::RX_FLUSH_BIT] && !sfr_req.wr |=>
    !fcn0[sfb_pkg::RX_FLUSH_BIT] && rx_byte_count == '0)
    else $error("rx flush did not clear");
  a_len_floor: assert property ( // see RL9
    clk_en && rx_byte.valid && master_mode && rx_mode && !sfr_req.wr
    && rx_length_field == 8'h00 |=> rx_length_field == 8'h00)
    else $error("length went below zero");
  // Enable low must freeze control, receive length, interrupt flag and read data
  a_ce_freeze: assert property (
    !clk_en |=> $stable(fcn0) && $stable(rx_length_field)
    && $stable(si_flag) && $stable(sfr_rdata))
    else $error("state moved while frozen");
endmodule

// [shared/sfb_pkg.sv]
/*
  Package for the SMBus FIFO block: register addresses, field
  positions, reset values and the carrier structs.
  Assumes an 8-bit special-function register port on the system clock.
*/
package sfb_pkg;
  localparam logic [7:0] ADDR_DATA = 8'hc2;
  localparam logic [7:0] ADDR_FCN0 = 8'hc3;
  localparam logic [7:0] ADDR_FCN1 = 8'hc4;
  localparam logic [7:0] ADDR_RX_LENGTH_FIELD = 8'hc5;
  localparam logic [7:0] ADDR_FCT = 8'hef;
  // Control zero field positions
  localparam int TX_REQUEST_IRQ_ENABLE_BIT = 7;
  localparam int TX_FLUSH_BIT = 6;
  localparam int TX_THRESHOLD_LSB = 4;
  localparam int RX_REQUEST_IRQ_ENABLE_BIT = 3;
  localparam int RX_FLUSH_BIT = 2;
  localparam int RX_THRESHOLD_LSB = 0;
  // Status flag positions
  localparam int TX_REQUEST_FLAG_BIT = 7;
  localparam int TX_NOT_FULL_BIT = 6;
  localparam int RX_REQUEST_FLAG_BIT = 3;
  localparam int RXE_BIT = 2;
  // Count field positions
  localparam int TX_BYTE_COUNT_LSB = 4;
  localparam int RX_BYTE_COUNT_LSB = 0;
  localparam logic [7:0] FCN0_RESET = 8'h00;
  localparam logic [7:0] RX_LENGTH_FIELD_RESET = 8'h00;
  localparam int FLUSH_CYCLES = 1;
  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfb_sfr_req_s;
  // Serial engine byte event
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sfb_byte_s;
endpackage

// [verification/sfb_engine_model.sv]
/*
  Serial engine stand-in: emits received bytes and drains transmit.
  Assumes the bench pulses send and holds drain_en as a level.
*/
`timescale 1ns/1ps
module sfb_engine_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Bench control
  input wire logic send,
  input wire logic [7:0] send_data,
  input wire logic drain_en,
  // Block side
  input wire logic tx_avail,
  input wire logic [7:0] tx_data,
  output sfb_pkg::sfb_byte_s rx_byte,
  output logic tx_take,
  output logic [7:0] last_tx,
  output logic [3:0] n_taken
);
  logic [1:0] gap;
  // Idle data toggles so a stale byte never looks settled
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) rx_byte <= '0;
    else if (send) rx_byte <= {1'b1, send_data};
    else rx_byte <= {1'b0, ~rx_byte.data};
  end
  // Gap lets the registered head settle after each take
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_take <= 1'b0;
      last_tx <= 8'h00;
      n_taken <= 4'h0;
      gap <= 2'h0;
    end else begin
      tx_take <= 1'b0;
      if (gap != 2'h0) gap <= gap - 2'h1;
      else if (drain_en && tx_avail) begin
        tx_take <= 1'b1;
        last_tx <= tx_data;
        n_taken <= n_taken + 4'h1;
        gap <= 2'h3;
      end
    end
  end
endmodule

// [verification/tb_top.sv]
/*
  Self-checking bench for the SMBus FIFO block.
  Assumes the engine model stands on the serial side.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
  typedef struct packed {logic [7:0] a; logic [7:0] e;} sfb_row_s;
  logic core_clk, sys_rst, master_mode, rx_mode, hw_ack_enable, ack_bit;
  logic si_clear, tx_take, tx_avail, si_flag, scl_hold, ack_out, smbus_irq;
  logic send, drain_en, si_set, clk_en;
  logic [7:0] sfr_rdata, tx_data, send_data, last_tx;
  logic [3:0] n_taken;
  sfb_pkg::sfb_sfr_req_s sfr_req;
  sfb_pkg::sfb_byte_s rx_byte;
  int n_mismatch = 0;
  int checks_done = 0;
  sfb_row_s rows [5] = '{'{8'hc3, 8'h00}, '{8'hc4, 8'hc4},
    '{8'hc5, 8'h00}, '{8'hef, 8'h00}, '{8'h10, 8'h00}};
  sfb_smbus_fifo #(.DEPTH(4), .BUF_DEPTH(16)) dut_u (.core_clk(core_clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .rx_byte(rx_byte), .master_mode(master_mode),
    .rx_mode(rx_mode), .hw_ack_enable(hw_ack_enable), .ack_bit(ack_bit),
    .si_set(si_set), .si_clear(si_clear), .tx_take(tx_take),
    .tx_data(tx_data), .tx_avail(tx_avail), .si_flag(si_flag),
    .scl_hold(scl_hold), .ack_out(ack_out), .smbus_irq(smbus_irq));
  sfb_engine_model eng_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .send(send), .send_data(send_data), .drain_en(drain_en),
    .tx_avail(tx_avail), .tx_data(tx_data), .rx_byte(rx_byte),
    .tx_take(tx_take), .last_tx(last_tx), .n_taken(n_taken));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_req <= '{1'b1, 1'b0, a, d};
    @(posedge core_clk);
    sfr_req.wr <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e,
                     input string nm);
    @(posedge core_clk);
    sfr_req.addr <= a;
    @(posedge core_clk);
    #1 `CHK(nm, e, sfr_rdata)
  endtask
  // Extra edge lets the staging buffer refill the head
  task automatic pop;
    @(posedge core_clk);
    sfr_req <= '{1'b0, 1'b1, sfb_pkg::ADDR_DATA, 8'h00};
    @(posedge core_clk);
    sfr_req.rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rx_send(input logic [7:0] d, input int gap);
    @(posedge core_clk);
    send <= 1'b1;
    send_data <= d;
    @(posedge core_clk);
    send <= 1'b0;
    repeat (gap) @(posedge core_clk);
    #1;
  endtask
  task automatic clear_si;
    @(posedge core_clk);
    si_clear <= 1'b1;
    @(posedge core_clk);
    si_clear <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    sfr_req = '0;
    {send, send_data, drain_en, si_clear} = '0;
    {si_set, clk_en} = 2'b01;
    {master_mode, rx_mode, hw_ack_enable, ack_bit} = '0;
    sys_rst = 1'b1;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) chk(rows[i].a, rows[i].e, "reset reg");
    $display("test reset done");
    for (int i = 1; i <= 4; i++) wr(sfb_pkg::ADDR_DATA, 8'(8'h11 * i));
    chk(sfb_pkg::ADDR_FCT, 8'h40, "tx count");
    chk(sfb_pkg::ADDR_FCN1, 8'h04, "status full");
    wr(sfb_pkg::ADDR_DATA, 8'h55);
    chk(sfb_pkg::ADDR_FCT, 8'h40, "tx count");
    drain_en <= 1'b1;
    for (int k = 0; k < 80 && n_taken != 4'h4; k++) @(posedge core_clk);
    drain_en <= 1'b0;
    `CHK("taken", 4'h4, n_taken)
    `CHK("last tx", 8'h55, last_tx)
    wr(sfb_pkg::ADDR_FCN0, 8'h90);
    wr(sfb_pkg::ADDR_DATA, 8'h01);
    wr(sfb_pkg::ADDR_DATA, 8'h02);
    chk(sfb_pkg::ADDR_FCN1, 8'h44, "tx request");
    `CHK("irq", 1'b0, smbus_irq)
    wr(sfb_pkg::ADDR_FCN0, 8'hd0);
    chk(sfb_pkg::ADDR_FCN0, 8'h90, "tx flush");
    chk(sfb_pkg::ADDR_FCT, 8'h00, "tx count");
    `CHK("irq", 1'b1, smbus_irq)
    wr(sfb_pkg::ADDR_FCN0, 8'h00);
    // Write while frozen must be lost
    clk_en <= 1'b0;
    wr(sfb_pkg::ADDR_DATA, 8'h77);
    clk_en <= 1'b1;
    chk(sfb_pkg::ADDR_FCT, 8'h00, "frozen write");
    $display("test tx done");
    {master_mode, rx_mode, hw_ack_enable, ack_bit} <= 4'hf;
    wr(sfb_pkg::ADDR_RX_LENGTH_FIELD, 8'h03);
    rx_send(8'ha0, 3);
    `CHK("ack", 1'b1, ack_out)
    ack_bit <= 1'b0;
    rx_send(8'ha1, 3);
    `CHK("ack", 1'b0, ack_out)
    rx_send(8'ha2, 3);
    `CHK("si", 1'b0, si_flag)
    chk(sfb_pkg::ADDR_RX_LENGTH_FIELD, 8'h00, "length");
    rx_send(8'ha3, 3);
    `CHK("si", 1'b1, si_flag)
    `CHK("hold", 1'b1, scl_hold)
    chk(sfb_pkg::ADDR_RX_LENGTH_FIELD, 8'h00, "length");
    chk(sfb_pkg::ADDR_FCT, 8'h04, "rx count");
    chk(sfb_pkg::ADDR_FCN1, 8'hc8, "rx request");
    wr(sfb_pkg::ADDR_FCN0, 8'h08);
    chk(sfb_pkg::ADDR_FCN0, 8'h08, "control");
    `CHK("irq", 1'b1, smbus_irq)
    for (int i = 0; i < 4; i++) begin
      chk(sfb_pkg::ADDR_DATA, 8'(8'ha0 + i), "rx data");
      pop();
    end
    chk(sfb_pkg::ADDR_FCN1, 8'hc4, "rx empty");
    chk(sfb_pkg::ADDR_DATA, 8'ha3, "rx underrun");
    pop();
    chk(sfb_pkg::ADDR_DATA, 8'ha3, "rx underrun");
    chk(sfb_pkg::ADDR_FCT, 8'h00, "rx count");
    `CHK("irq", 1'b0, smbus_irq)
    clear_si();
    `CHK("hold", 1'b0, scl_hold)
    si_set <= 1'b1;
    @(posedge core_clk);
    si_set <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 `CHK("si", 1'b1, si_flag)
    `CHK("hold", 1'b1, scl_hold)
    clear_si();
    `CHK("si", 1'b0, si_flag)
    $display("test master rx done");
    master_mode <= 1'b0;
    rx_send(8'hb0, 3);
    `CHK("si", 1'b1, si_flag)
    clear_si();
    // Length changes only with the bus idle or stalled
    wr(sfb_pkg::ADDR_RX_LENGTH_FIELD, 8'h05);
    rx_send(8'hb1, 3);
    `CHK("si", 1'b0, si_flag)
    chk(sfb_pkg::ADDR_RX_LENGTH_FIELD, 8'h05, "length");
    wr(sfb_pkg::ADDR_FCN0, 8'h04);
    chk(sfb_pkg::ADDR_FCN0, 8'h00, "rx flush");
    chk(sfb_pkg::ADDR_FCT, 8'h00, "rx count");
    for (int i = 0; i < 21; i++) rx_send(8'(i), 1);
    `CHK("hold", 1'b1, scl_hold)
    chk(sfb_pkg::ADDR_FCT, 8'h04, "rx count");
    for (int i = 0; i < 20; i++) begin
      chk(sfb_pkg::ADDR_DATA, 8'(i), "rx data");
      pop();
    end
    chk(sfb_pkg::ADDR_FCN1, 8'hc4, "rx empty");
    $display("test slave rx done");
    report_and_stop();
  end
endmodule
